// *** dv/ccs_mem_model.sv ***
`timescale 1ns/1ns
module ccs_mem_model
(
    input wire logic                  ref_clk,
    input wire ccs_pkg::ccs_mem_req_t mem_req,
    output logic [7:0]                mem_rdata
);
    import ccs_pkg::*;
    logic [7:0] mem [4096];  // whole banked data space

    initial
    begin
        mem_rdata = 8'h00;
        foreach (mem[i])
            mem[i] = i[7:0] ^ 8'hA5;
    end

    // read byte stands one cycle, then toggles to its inverse every cycle until the next read
    always @(posedge ref_clk)
    begin
        if (mem_req.rd)
            mem_rdata <= mem[mem_req.addr];
        else
            mem_rdata <= ~mem_rdata;
        if (mem_req.wr)
            mem[mem_req.addr] <= mem_req.wdata;
    end
endmodule

// *** dv/ccs_props.sv ***
`timescale 1ns/1ns
module ccs_props
(
    input wire logic                   ref_clk,
    input wire logic                   rst_n,
    input wire logic                   instr_valid,
    input wire logic [15:0]            instr_word,
    input wire logic [7:0]             mem_rdata,
    input wire ccs_pkg::ccs_mem_req_t  mem_req,
    input wire ccs_pkg::ccs_core_upd_t core_upd,
    input wire logic                   ready,
    input wire logic                   discard_fetch,
    input wire logic                   skip_nop,
    input wire logic                   done
);
    import ccs_pkg::*;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    // ----
    // request decode
    // ----
    wire logic       is_cmf = instr_word[15:10] == CCS_OP_COMPLEMENT;   // complement word
    wire logic       is_cmp = instr_word[15:9] inside {CCS_OP_CMP_EQUAL, CCS_OP_CMP_GREAT, CCS_OP_CMP_LESS};
    wire logic       take   = ready && instr_valid && (is_cmf || is_cmp);  // accepted word
    logic      [7:0] inv_q;                                                // inverse of last read byte

    // previous read data, inverted, to judge the complement result
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            inv_q <= 8'h00;
        else
            inv_q <= ~mem_rdata;
    end

    // ----
    // properties
    // ----
    AST_READ_AFTER_TAKE: assert property (take |-> ##2 mem_req.rd)
        else $error("no read two cycles after accept");
    AST_CMF_TO_REG: assert property (take && is_cmf && instr_word[9] |-> ##4 (mem_req.wr && !core_upd.acc_wr && core_upd.flag_wr && done))
        else $error("complement d=1 did not write the register");
    AST_CMF_TO_ACC: assert property (take && is_cmf && !instr_word[9] |-> ##4 (core_upd.acc_wr && !mem_req.wr && core_upd.flag_wr && done))
        else $error("complement d=0 did not write the accumulator");
    AST_CMF_DATA: assert property (mem_req.wr || core_upd.acc_wr |-> (mem_req.wr ? mem_req.wdata : core_upd.acc_data) == inv_q)
        else $error("written value is not the inverted byte");
    AST_CMF_FLAGS: assert property (core_upd.flag_wr |-> core_upd.flag_n == inv_q[7] && core_upd.flag_z == (inv_q == 8'h00))
        else $error("negative or zero flag wrong");
    AST_CMP_QUIET: assert property (take && is_cmp |-> ##1 (!core_upd.flag_wr && !core_upd.acc_wr && !mem_req.wr) [*8])
        else $error("compare wrote a flag or a result");
    AST_CMP_END: assert property (take && is_cmp |-> ##4 (done ^ discard_fetch))
        else $error("compare neither finished nor skipped in its fourth phase");
    AST_SKIP_LEN: assert property (discard_fetch |=> skip_nop [*4])
        else $error("skip shorter than one instruction cycle");
    AST_SKIP_NOTHING: assert property (skip_nop |-> !(mem_req.wr || mem_req.rd || core_upd.acc_wr || core_upd.flag_wr))
        else $error("activity during a skip cycle");

    COV_CMF: cover property (take && is_cmf);
    COV_SKIP: cover property (discard_fetch);
    COV_LONG_SKIP: cover property (skip_nop [*8]);
endmodule

// *** dv/complement_compare_skip_exec_test.sv ***
`timescale 1ns/1ns
module complement_compare_skip_exec_test;
    import ccs_pkg::*;
    logic          ref_clk = 1'b0;
    logic          rst_n = 1'b0;
    logic          instr_valid = 1'b0;
    logic [15:0]   instr_word = 16'h0000;
    logic          next_two_word = 1'b0;
    logic          ext_set_en = 1'b0;
    logic [3:0]    bank_select_register = 4'h0;
    logic [11:0]   index_base = 12'h2F0;
    logic [7:0]    working_accumulator = 8'h00;
    logic [7:0]    mem_rdata;
    ccs_mem_req_t  mem_req;
    ccs_core_upd_t core_upd;
    logic          ready, discard_fetch, skip_nop, done;
    int            n_errors = 0;
    int            total_checks = 0;
    int            cyc, n_rd, n_wr, n_acc, n_flag, n_disc, n_nop;  // per instruction
    logic [11:0]   rd_addr;
    logic [7:0]    wr_data, acc_data;
    logic          fl_n, fl_z;

    always #25 ref_clk = ~ref_clk;

    ccs_exec i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .instr_valid(instr_valid), .instr_word(instr_word),
        .next_two_word(next_two_word), .ext_set_en(ext_set_en), .bank_select_register(bank_select_register),
        .index_base(index_base), .working_accumulator(working_accumulator), .mem_rdata(mem_rdata),
        .mem_req(mem_req), .core_upd(core_upd), .ready(ready), .discard_fetch(discard_fetch),
        .skip_nop(skip_nop), .done(done));
    ccs_mem_model i_mem (.ref_clk(ref_clk), .mem_req(mem_req), .mem_rdata(mem_rdata));

    // ----
    // shared tasks
    // ----
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED %0t value mismatch got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic conclude();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // offer one word at a falling edge, then log every phase until done or 20 phases
    task automatic exec(input logic [15:0] w, input logic tw);
        int k;
        k = 0;
        while (ready !== 1'b1 && k < 30)
        begin
            @(negedge ref_clk);
            k++;
        end
        chk(ready, 1'b1);
        instr_word = w;
        instr_valid = 1'b1;
        next_two_word = tw;
        @(negedge ref_clk);
        instr_valid = 1'b0;
        {n_rd, n_wr, n_acc, n_flag, n_disc, n_nop} = '0;
        cyc = 1;
        repeat (20)
        begin
            if (mem_req.rd === 1'b1)
            begin
                n_rd++;
                rd_addr = mem_req.addr;
            end
            if (mem_req.wr === 1'b1)
            begin
                n_wr++;
                wr_data = mem_req.wdata;
            end
            if (core_upd.acc_wr === 1'b1)
            begin
                n_acc++;
                acc_data = core_upd.acc_data;
            end
            if (core_upd.flag_wr === 1'b1)
            begin
                n_flag++;
                {fl_n, fl_z} = {core_upd.flag_n, core_upd.flag_z};
            end
            n_disc += (discard_fetch === 1'b1);
            n_nop += (skip_nop === 1'b1);
            if (done === 1'b1)
                break;
            @(negedge ref_clk);
            cyc++;
        end
    endtask

    // ----
    // scenarios
    // ----
    // complement into accumulator and register, zero and negative results
    task automatic t_complement();
        logic [7:0] v[3] = '{8'h13, 8'h00, 8'hFF};
        logic [7:0] e;
        bank_select_register = 4'h3;
        for (int i = 0; i < 3; i++)
        begin
            i_mem.mem[12'h342] = v[i];
            e = ~v[i];
            exec({CCS_OP_COMPLEMENT, i != 0, 1'b1, 8'h42}, 1'b0);
            chk(rd_addr, 12'h342);
            chk(cyc, 4);
            chk(i != 0 ? wr_data : acc_data, e);
            chk(n_wr, i != 0);
            chk(n_acc, i == 0);
            chk({n_flag, fl_n, fl_z}, {1'b1, e[7], e == 8'h00});
        end
    endtask

    // access bank halves, indexed offset edge, banked page
    task automatic t_addressing();
        logic [7:0]  f[5] = '{8'h10, 8'h80, 8'h5F, 8'h60, 8'h20};
        logic [1:0]  ea[5] = '{2'b00, 2'b00, 2'b10, 2'b10, 2'b11};
        logic [11:0] e[5] = '{12'h010, 12'hF80, 12'h34F, 12'hF60, 12'h520};
        bank_select_register = 4'h5;
        for (int i = 0; i < 5; i++)
        begin
            ext_set_en = ea[i][1];
            exec({CCS_OP_CMP_LESS, ea[i][0], f[i]}, 1'b0);
            chk(rd_addr, e[i]);
        end
        ext_set_en = 1'b0;
    endtask

    // every compare against unsigned boundary pairs
    task automatic t_compares();
        logic [7:0] f[5] = '{8'h80, 8'h7F, 8'h55, 8'h00, 8'hFF};
        logic [7:0] w[5] = '{8'h7F, 8'h80, 8'h55, 8'hFF, 8'h00};
        logic [6:0] op[3] = '{CCS_OP_CMP_EQUAL, CCS_OP_CMP_GREAT, CCS_OP_CMP_LESS};
        logic       sk;
        bank_select_register = 4'h1;
        for (int o = 0; o < 3; o++)
            for (int i = 0; i < 5; i++)
            begin
                i_mem.mem[12'h1A0] = f[i];
                working_accumulator = w[i];
                exec({op[o], 1'b1, 8'hA0}, 1'b0);
                sk = o == 0 ? f[i] == w[i] : (o == 1 ? f[i] > w[i] : f[i] < w[i]);
                chk(n_disc, sk);
                chk(cyc, sk ? 8 : 4);
                chk(n_nop, sk ? 4 : 0);
                chk(n_flag + n_acc + n_wr, 0);
            end
    endtask

    // skipped two-word follower, and a two-word follower that is kept
    task automatic t_two_word();
        bank_select_register = 4'h1;
        i_mem.mem[12'h1A0] = 8'h21;
        working_accumulator = 8'h21;
        exec({CCS_OP_CMP_EQUAL, 1'b1, 8'hA0}, 1'b1);
        chk(cyc, 12);
        chk(n_nop, 8);
        working_accumulator = 8'h22;
        exec({CCS_OP_CMP_EQUAL, 1'b1, 8'hA0}, 1'b1);
        chk(cyc, 4);
        next_two_word = 1'b0;
    endtask

    // a word outside the four handled ones is never started
    task automatic t_foreign();
        exec(16'h6A42, 1'b0);
        chk(n_rd + n_wr + n_acc, 0);
    endtask

    // watchdog: about 30 instructions of at most 30 phases fit well inside this span
    initial
    begin
        #400000;
        n_errors++;
        conclude();
    end

    initial
    begin
        repeat (12) @(negedge ref_clk);
        rst_n = 1'b1;
        repeat (2) @(negedge ref_clk);
        t_complement();
        t_addressing();
        t_compares();
        t_two_word();
        t_foreign();
        conclude();
    end
endmodule

bind ccs_exec ccs_props i_props (.ref_clk(ref_clk), .rst_n(rst_n), .instr_valid(instr_valid),
    .instr_word(instr_word), .mem_rdata(mem_rdata), .mem_req(mem_req), .core_upd(core_upd),
    .ready(ready), .discard_fetch(discard_fetch), .skip_nop(skip_nop), .done(done));

// *** rtl/ccs_addr_gen.sv ***
`timescale 1ns/1ns
module ccs_addr_gen
(
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic        load,
    input  wire logic        access_sel,
    input  wire logic [7:0]  freg,
    input  wire logic        ext_set_en,
    input  wire logic [3:0]  bank_select_register,
    input  wire logic [11:0] index_base,
    output logic      [11:0] addr_q
);
    import ccs_pkg::*;

    logic [11:0] addr_d;  // address formed from operand bits

    // ------------------------------------------------------------
    // address formation
    // ------------------------------------------------------------
    always_comb
    begin
        if (access_sel)
        begin
            // banked: bank select register picks the page
            addr_d = {bank_select_register, freg};
        end
        else if (ext_set_en && (freg <= CCS_INDEX_MAX))
        begin
            // indexed literal offset from the index base
            addr_d = index_base + {4'h0, freg};
        end
        else if (freg <= CCS_INDEX_MAX)
        begin
            // low access half
            addr_d = {CCS_ACC_LO_BANK, freg};
        end
        else
        begin
            // high access half
            addr_d = {CCS_ACC_HI_BANK, freg};
        end
    end

    // registered so the memory sees a clean address in the read phase
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            addr_q <= CCS_ADDR_RESET;
        end
        else if (load)
        begin
            addr_q <= addr_d;
        end
    end

endmodule

// *** rtl/ccs_exec.sv ***
// Operation
// - complement writes inverted byte, sets N Z
// - destination bit picks accumulator or register
// - access bit picks access or banked
// - extended set, access, small offset: indexed
// - compares use unsigned subtraction, store nothing
// - equal compare skips when byte equals accumulator
// - greater compare skips when byte is greater
// - less compare skips when byte is less
// - skip discards fetch, adds one nop cycle
// - skipped two-word instruction makes three cycles
// - skip cycles do nothing, write nothing
`timescale 1ns/1ns
module ccs_exec
(
    input  wire logic                   ref_clk,
    input  wire logic                   rst_n,
    input  wire logic                   instr_valid,
    input  wire logic [15:0]            instr_word,
    input  wire logic                   next_two_word,
    input  wire logic                   ext_set_en,
    input  wire logic [3:0]             bank_select_register,
    input  wire logic [11:0]            index_base,
    input  wire logic [7:0]             working_accumulator,
    input  wire logic [7:0]             mem_rdata,
    output ccs_pkg::ccs_mem_req_t       mem_req,
    output ccs_pkg::ccs_core_upd_t      core_upd,
    output logic                        ready,
    output logic                        discard_fetch,
    output logic                        skip_nop,
    output logic                        done
);
    import ccs_pkg::*;

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    ccs_state_t    state_q;        // sequencer state
    ccs_state_t    state_d;        // next sequencer state
    logic [15:0]   instr_q;        // held instruction
    logic          is_comp;        // complement opcode seen
    logic          is_eq;          // equal compare seen
    logic          is_gt;          // greater compare seen
    logic          is_lt;          // less compare seen
    logic          known;          // one of our four opcodes
    logic          take;           // instruction accepted this edge
    logic [11:0]   addr_q;         // operand address from generator
    logic [8:0]    diff;           // byte minus accumulator, with borrow
    logic          cond;           // skip condition of held compare
    logic [7:0]    inv;            // inverted operand byte
    logic          skip_q;         // skip decided in process phase
    logic          two_q;          // skipped word is two words long
    logic [3:0]    nop_cnt_q;      // phases left in skip cycles
    ccs_mem_req_t  mem_req_q;      // registered memory request
    ccs_core_upd_t core_upd_q;     // registered core update
    logic          ready_q;        // idle and able to take a word
    logic          discard_q;      // discard pulse
    logic          done_q;         // last phase pulse

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    // opcode match on the incoming word when idle, else held word
    logic [15:0] dec_word;
    assign dec_word = (state_q == CCS_IDLE) ? instr_word : instr_q;
    assign is_comp  = dec_word[CCS_OP6_HI:CCS_OP6_LO] == CCS_OP_COMPLEMENT;
    assign is_eq    = dec_word[CCS_OP6_HI:CCS_OP7_LO] == CCS_OP_CMP_EQUAL;
    assign is_gt    = dec_word[CCS_OP6_HI:CCS_OP7_LO] == CCS_OP_CMP_GREAT;
    assign is_lt    = dec_word[CCS_OP6_HI:CCS_OP7_LO] == CCS_OP_CMP_LESS;
    assign known    = is_comp | is_eq | is_gt | is_lt;
    // words for other instructions are left for other units
    // ready gate keeps the first edge after reset from taking a word
    assign take     = (state_q == CCS_IDLE) && ready_q && instr_valid && known;

    // ------------------------------------------------------------
    // data path
    // ------------------------------------------------------------
    // unsigned subtraction
    assign diff = {1'b0, mem_rdata} - {1'b0, working_accumulator};
    assign inv  = ~mem_rdata;

    always_comb
    begin
        if (is_eq)
        begin
            cond = (diff == 9'h000);
        end
        else if (is_gt)
        begin
            cond = !diff[8] && (diff != 9'h000);
        end
        else if (is_lt)
        begin
            cond = diff[8];
        end
        else
        begin
            cond = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // operand address
    // ------------------------------------------------------------
    // formed at the take edge, so the read strobe already carries it
    // bank and indexed selection
    ccs_addr_gen u_addr
    (
        .ref_clk              (ref_clk),
        .rst_n                (rst_n),
        .load                 (take),
        .access_sel           (dec_word[CCS_ACC_BIT]),
        .freg                 (dec_word[CCS_FREG_HI:CCS_FREG_LO]),
        .ext_set_en           (ext_set_en),
        .bank_select_register (bank_select_register),
        .index_base           (index_base),
        .addr_q               (addr_q)
    );

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            CCS_IDLE:
            begin
                if (take)
                begin
                    state_d = CCS_DEC;
                end
            end
            CCS_DEC:   state_d = CCS_READ;
            CCS_READ:  state_d = CCS_PROC;
            CCS_PROC:  state_d = CCS_WRITE;
            CCS_WRITE:
            begin
                state_d = skip_q ? CCS_SKIP : CCS_IDLE;
            end
            CCS_SKIP:
            begin
                if (nop_cnt_q == 4'h1)
                begin
                    state_d = CCS_IDLE;
                end
            end
            default:   state_d = CCS_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q <= CCS_IDLE;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // instruction hold, taken in the idle cycle
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            instr_q <= 16'h0000;
        end
        else if (take)
        begin
            instr_q <= instr_word;
        end
    end

    // ------------------------------------------------------------
    // skip decision and nop counting
    // ------------------------------------------------------------
    // decided in process, since the byte is only valid then
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            skip_q <= 1'b0;
            two_q  <= 1'b0;
        end
        else if (state_q == CCS_PROC)
        begin
            skip_q <= cond;
            two_q  <= next_two_word;
        end
    end

    // phases of the nop cycles
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            nop_cnt_q <= 4'h0;
        end
        else if (state_q == CCS_WRITE)
        begin
            nop_cnt_q <= two_q ? CCS_PHASES_TWO : CCS_PHASES;
        end
        else if (state_q == CCS_SKIP)
        begin
            nop_cnt_q <= nop_cnt_q - 4'h1;
        end
    end

    // ------------------------------------------------------------
    // memory request
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mem_req_q <= '0;
        end
        else
        begin
            mem_req_q.addr  <= (state_d == CCS_IDLE) ? CCS_ADDR_RESET : addr_q;
            mem_req_q.rd    <= (state_q == CCS_DEC);
            // write back to register when dest is one
            mem_req_q.wr    <= (state_q == CCS_PROC) && is_comp && instr_q[CCS_DEST_BIT];
            mem_req_q.wdata <= ((state_q == CCS_PROC) && is_comp) ? inv : CCS_BYTE_RESET;
        end
    end

    // ------------------------------------------------------------
    // accumulator and flags
    // ------------------------------------------------------------
    // compares never reach the flag strobe
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            core_upd_q <= '0;
        end
        else if ((state_q == CCS_PROC) && is_comp)
        begin
            core_upd_q.flag_wr  <= 1'b1;
            core_upd_q.flag_n   <= inv[7];
            core_upd_q.flag_z   <= (inv == CCS_BYTE_RESET);
            core_upd_q.acc_wr   <= !instr_q[CCS_DEST_BIT];
            core_upd_q.acc_data <= inv;
        end
        else
        begin
            // nothing written outside the write phase
            core_upd_q <= '0;
        end
    end

    // ------------------------------------------------------------
    // pipeline handshakes
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ready_q   <= 1'b0;
            discard_q <= 1'b0;
            done_q    <= 1'b0;
        end
        else
        begin
            ready_q   <= (state_d == CCS_IDLE);
            discard_q <= (state_q == CCS_PROC) && cond;
            // done stands in the fourth phase of the last cycle
            done_q    <= ((state_q == CCS_PROC) && !cond)
                      || ((state_q == CCS_SKIP) && (nop_cnt_q == 4'h2));
        end
    end

    // nop phases flagged to the core
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            skip_nop <= 1'b0;
        end
        else
        begin
            skip_nop <= (state_d == CCS_SKIP);
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign mem_req       = mem_req_q;
    assign core_upd      = core_upd_q;
    assign ready         = ready_q;
    assign discard_fetch = discard_q;
    assign done          = done_q;

endmodule

// *** rtl/ccs_pkg.sv ***
package ccs_pkg;

    // ------------------------------------------------------------
    // instruction encodings
    // ------------------------------------------------------------
    localparam logic [5:0] CCS_OP_COMPLEMENT = 6'h07;  // 0001 11 d a
    localparam logic [6:0] CCS_OP_CMP_EQUAL  = 7'h31;  // 0110 001 a
    localparam logic [6:0] CCS_OP_CMP_GREAT  = 7'h32;  // 0110 010 a
    localparam logic [6:0] CCS_OP_CMP_LESS   = 7'h30;  // 0110 000 a

    // ------------------------------------------------------------
    // field positions in the instruction word
    // ------------------------------------------------------------
    localparam int CCS_OP6_HI   = 15;  // top of the six-bit opcode
    localparam int CCS_OP6_LO   = 10;  // bottom of the six-bit opcode
    localparam int CCS_OP7_LO   = 9;   // bottom of the seven-bit opcode
    localparam int CCS_DEST_BIT = 9;   // destination select
    localparam int CCS_ACC_BIT  = 8;   // access / banked select
    localparam int CCS_FREG_HI  = 7;   // register field top
    localparam int CCS_FREG_LO  = 0;   // register field bottom

    // ------------------------------------------------------------
    // addressing constants
    // ------------------------------------------------------------
    localparam logic [7:0] CCS_INDEX_MAX    = 8'h5F;  // last offset using indexed mode
    localparam logic [3:0] CCS_ACC_LO_BANK  = 4'h0;   // low access half lives in bank 0
    localparam logic [3:0] CCS_ACC_HI_BANK  = 4'hF;   // high access half is special regs
    localparam logic [3:0] CCS_PHASES       = 4'h4;   // phases per instruction cycle
    localparam logic [3:0] CCS_PHASES_TWO   = 4'h8;   // two nop cycles
    localparam logic [7:0] CCS_BYTE_RESET   = 8'h00;  // reset value for data registers
    localparam logic [11:0] CCS_ADDR_RESET  = 12'h000; // reset value for addresses

    // ------------------------------------------------------------
    // sequencer states, gray along decode -> write -> skip
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        CCS_IDLE  = 3'h0,
        CCS_DEC   = 3'h1,
        CCS_READ  = 3'h3,
        CCS_PROC  = 3'h2,
        CCS_WRITE = 3'h6,
        CCS_SKIP  = 3'h7
    } ccs_state_t;

    // ------------------------------------------------------------
    // data memory request carrier
    // ------------------------------------------------------------
    typedef struct packed {
        logic [11:0] addr;   // banked data memory address
        logic        rd;     // read strobe
        logic        wr;     // write strobe
        logic [7:0]  wdata;  // write data
    } ccs_mem_req_t;

    // accumulator and flag update carrier
    typedef struct packed {
        logic       acc_wr;    // write the working accumulator
        logic [7:0] acc_data;  // new accumulator value
        logic       flag_wr;   // update negative and zero
        logic       flag_n;    // negative flag value
        logic       flag_z;    // zero flag value
    } ccs_core_upd_t;

endpackage
